// >>> hw/pfmc_pin_function_mux.sv
// Pin function selector registers with compatibility-mode forcing
`include "pfmc_consts.svh"
`default_nettype none

module pfmc_pin_function_mux #(
   parameter int AW = 4
) (
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic                   compat_mode,
   input  wire logic [AW-1:0]          reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output var  logic [31:0]            reg_rdata,
   output var  pfmc_pkg::pfmc_pin_sel_s pin_sel
);
   import pfmc_pkg::*;

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   generate
      if (AW < 4)
      begin : g_bad_aw
         $error("pfmc: AW must be at least 4");
      end
   endgenerate

   // ---------------------------------------------------------------
   // Compatibility mode synchroniser
   // ---------------------------------------------------------------
   logic compat_meta_q;
   logic compat_q;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         compat_meta_q <= 1'b0;
         compat_q      <= 1'b0;
      end
      else
      begin
         compat_meta_q <= compat_mode;
         compat_q      <= compat_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   logic [AW-1:0] ofs_b;
   logic [AW-1:0] ofs_c;
   logic [AW-1:0] ofs_d;
   logic          hit_b;
   logic          hit_c;
   logic          hit_d;

   assign ofs_b = AW'(`PFMC_OFS_SELECT_B);
   assign ofs_c = AW'(`PFMC_OFS_SELECT_C);
   assign ofs_d = AW'(`PFMC_OFS_SELECT_D);
   assign hit_b = (reg_addr == ofs_b);
   assign hit_c = (reg_addr == ofs_c);
   assign hit_d = (reg_addr == ofs_d);

   // ---------------------------------------------------------------
   // Selector registers
   // ---------------------------------------------------------------
   logic [31:0] sel_b_q;
   logic [31:0] sel_c_q;
   logic [31:0] sel_d_q;

   // Reserved bits are not stored, so they read as zero
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         sel_b_q <= `PFMC_RST_VALUE;
      else if (compat_q)
         sel_b_q <= `PFMC_RST_VALUE;
      else if (reg_wr && hit_b)
         sel_b_q <= reg_wdata & `PFMC_MASK_B;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         sel_c_q <= `PFMC_RST_VALUE;
      else if (compat_q)
         sel_c_q <= `PFMC_RST_VALUE;
      else if (reg_wr && hit_c)
         sel_c_q <= reg_wdata & `PFMC_MASK_C;
   end

   // Not affected by compatibility mode
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         sel_d_q <= `PFMC_RST_VALUE;
      else if (reg_wr && hit_d)
         sel_d_q <= reg_wdata & `PFMC_MASK_D;
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   logic [31:0] rdata_d;

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (reg_rd)
      begin
         if (hit_b)
            rdata_d = sel_b_q;
         else if (hit_c)
            rdata_d = sel_c_q;
         else if (hit_d)
            rdata_d = sel_d_q;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 32'h0000_0000;
      else
         reg_rdata <= rdata_d;
   end

   // ---------------------------------------------------------------
   // Pad selector outputs
   // ---------------------------------------------------------------
   // Driven straight from the selector flops
   always_comb
   begin
      pin_sel.uart_clock_request_pin_select      = sel_b_q[`PFMC_B_UART_CLKREQ +: 3];
      pin_sel.serial_if2_sync_pin_select         = sel_b_q[`PFMC_B_SIF2_SYNC +: 3];
      pin_sel.serial_if2_dataout_pin_select      = sel_b_q[`PFMC_B_SIF2_DOUT +: 3];
      pin_sel.serial_if2_datain_pin_select       = sel_b_q[`PFMC_B_SIF2_DIN +: 3];
      pin_sel.serial_if2_clock_pin_select        = sel_b_q[`PFMC_B_SIF2_CLK +: 3];
      pin_sel.second_uart_transmit_pin_select    = sel_c_q[`PFMC_C_UART2_TX +: 3];
      pin_sel.second_uart_rts_pin_select         = sel_c_q[`PFMC_C_UART2_RTS +: 3];
      pin_sel.second_uart_cts_pin_select         = sel_c_q[`PFMC_C_UART2_CTS +: 3];
      pin_sel.second_uart_receive_pin_select     = sel_c_q[`PFMC_C_UART2_RX +: 3];
      pin_sel.buffered_port2_dataout_pin_select  = sel_c_q[`PFMC_C_BSP2_DOUT +: 3];
      pin_sel.buffered_port2_rx_frame_pin_select = sel_c_q[`PFMC_C_BSP2_RXFRM +: 3];
      pin_sel.buffered_port2_rx_clock_pin_select = sel_c_q[`PFMC_C_BSP2_RXCLK +: 3];
      pin_sel.buffered_port2_datain_pin_select   = sel_c_q[`PFMC_C_BSP2_DIN +: 3];
      pin_sel.card_data3_pin_select              = sel_d_q[`PFMC_D_CARD_DAT3 +: 3];
      pin_sel.flash_select2_pin_select           = sel_d_q[`PFMC_D_FLASH_CS2 +: 3];
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_reset_clears;
      @(posedge clk) $rose(resetn) |-> (sel_b_q == 32'h0) && (sel_c_q == 32'h0)
         && (sel_d_q == 32'h0) && (pin_sel == '0);
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("selectors not cleared after reset");

   property p_compat_holds_bc;
      @(posedge clk) disable iff (!resetn)
      compat_mode [*4] |-> (sel_b_q == 32'h0) && (sel_c_q == 32'h0);
   endproperty
   a_compat_holds_bc: assert property (p_compat_holds_bc)
      else $error("B or C not held at zero in compatibility mode");

   property p_compat_blocks_write;
      @(posedge clk) disable iff (!resetn)
      (compat_q && reg_wr && hit_c) |=> (sel_c_q == 32'h0);
   endproperty
   a_compat_blocks_write: assert property (p_compat_blocks_write)
      else $error("write to C took effect in compatibility mode");

   property p_d_ignores_compat;
      @(posedge clk) disable iff (!resetn)
      (compat_q && reg_wr && hit_d) |=> (sel_d_q == ($past(reg_wdata) & 32'h0000_71C0));
   endproperty
   a_d_ignores_compat: assert property (p_d_ignores_compat)
      else $error("D write lost in compatibility mode");

   property p_d_stable;
      @(posedge clk) disable iff (!resetn)
      !(reg_wr && hit_d) |=> $stable(sel_d_q);
   endproperty
   a_d_stable: assert property (p_d_stable)
      else $error("D changed without a write");

   property p_b_write_lands;
      @(posedge clk) disable iff (!resetn)
      (!compat_q && reg_wr && hit_b) ##1 !compat_q
         |-> (pin_sel.serial_if2_sync_pin_select == $past(reg_wdata[14:12]))
         && (pin_sel.uart_clock_request_pin_select == $past(reg_wdata[20:18]));
   endproperty
   a_b_write_lands: assert property (p_b_write_lands)
      else $error("B write did not reach the pad selectors");

   property p_c_layout;
      @(posedge clk) disable iff (!resetn)
      (pin_sel.second_uart_transmit_pin_select == sel_c_q[29:27])
         && (pin_sel.buffered_port2_datain_pin_select == sel_c_q[2:0])
         && (pin_sel.buffered_port2_rx_clock_pin_select == sel_c_q[8:6]);
   endproperty
   a_c_layout: assert property (p_c_layout)
      else $error("C fields routed to wrong pads");

   property p_reserved_zero;
      @(posedge clk) disable iff (!resetn)
      $past(reg_rd) |-> (reg_rdata[31:30] == 2'h0)
         && !($past(hit_b) && ((reg_rdata & ~`PFMC_MASK_B) != 32'h0))
         && !($past(hit_c) && (reg_rdata[11:9] != 3'h0))
         && !($past(hit_d) && (reg_rdata[31:15] != 17'h0));
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read non-zero");

   property p_read_returns;
      @(posedge clk) disable iff (!resetn)
      (reg_rd && hit_d) |=> (reg_rdata == $past(sel_d_q));
   endproperty
   a_read_returns: assert property (p_read_returns)
      else $error("read data does not match stored value");

   property p_rdata_idle;
      @(posedge clk) disable iff (!resetn)
      !reg_rd |=> (reg_rdata == 32'h0);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside the read answer cycle");

   c_write_b:   cover property (@(posedge clk) disable iff (!resetn)
                                reg_wr && hit_b && !compat_q);
   c_compat_on: cover property (@(posedge clk) disable iff (!resetn)
                                $rose(compat_q) && (sel_c_q != 32'h0));
   c_d_compat:  cover property (@(posedge clk) disable iff (!resetn)
                                compat_q && reg_wr && hit_d);
   c_read_wr:   cover property (@(posedge clk) disable iff (!resetn)
                                reg_wr ##1 reg_rd);

endmodule : pfmc_pin_function_mux
`default_nettype wire

// >>> hw/pfmc_consts.svh
// Offsets, field positions and reset values of the pin function selectors
`ifndef PFMC_CONSTS_SVH
`define PFMC_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PFMC_OFS_SELECT_B 4'h0
`define PFMC_OFS_SELECT_C 4'h4
`define PFMC_OFS_SELECT_D 4'h8

// ---------------------------------------------------------------
// Reset values and writable field masks
// ---------------------------------------------------------------
`define PFMC_RST_VALUE    32'h0000_0000
`define PFMC_SEL_DEFAULT  3'h0
`define PFMC_MASK_B       32'h001C_7FF8
`define PFMC_MASK_C       32'h3FFF_F1C7
`define PFMC_MASK_D       32'h0000_71C0

// ---------------------------------------------------------------
// Field low bit positions
// ---------------------------------------------------------------
`define PFMC_B_UART_CLKREQ  18
`define PFMC_B_SIF2_SYNC    12
`define PFMC_B_SIF2_DOUT    9
`define PFMC_B_SIF2_DIN     6
`define PFMC_B_SIF2_CLK     3
`define PFMC_C_UART2_TX     27
`define PFMC_C_UART2_RTS    24
`define PFMC_C_UART2_CTS    21
`define PFMC_C_UART2_RX     18
`define PFMC_C_BSP2_DOUT    15
`define PFMC_C_BSP2_RXFRM   12
`define PFMC_C_BSP2_RXCLK   6
`define PFMC_C_BSP2_DIN     0
`define PFMC_D_CARD_DAT3    12
`define PFMC_D_FLASH_CS2    6

`endif

// >>> hw/pfmc_pkg.sv
// Types shared by the pin function selector block
`default_nettype none
package pfmc_pkg;
   typedef logic [2:0] pfmc_sel_t;

   typedef struct packed {
      pfmc_sel_t uart_clock_request_pin_select;
      pfmc_sel_t serial_if2_sync_pin_select;
      pfmc_sel_t serial_if2_dataout_pin_select;
      pfmc_sel_t serial_if2_datain_pin_select;
      pfmc_sel_t serial_if2_clock_pin_select;
      pfmc_sel_t second_uart_transmit_pin_select;
      pfmc_sel_t second_uart_rts_pin_select;
      pfmc_sel_t second_uart_cts_pin_select;
      pfmc_sel_t second_uart_receive_pin_select;
      pfmc_sel_t buffered_port2_dataout_pin_select;
      pfmc_sel_t buffered_port2_rx_frame_pin_select;
      pfmc_sel_t buffered_port2_rx_clock_pin_select;
      pfmc_sel_t buffered_port2_datain_pin_select;
      pfmc_sel_t card_data3_pin_select;
      pfmc_sel_t flash_select2_pin_select;
   } pfmc_pin_sel_s;
endpackage : pfmc_pkg
`default_nettype wire

// >>> sim/tb_pfmc_pin_function_mux.sv
// Self-checking bench for the pin function selector registers
`include "pfmc_consts.svh"
`default_nettype none
module tb_pfmc_pin_function_mux;
   timeunit 1ns;
   timeprecision 1ps;
   import pfmc_pkg::*;

   logic          clk;
   logic          resetn;
   logic          compat_mode;
   logic [3:0]    reg_addr;
   logic [31:0]   reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [31:0]   reg_rdata;
   pfmc_pin_sel_s pin_sel;
   int            n_errors;
   int            tests_run;
   int            cycles;
   logic [31:0]   sh_b;
   logic [31:0]   sh_c;
   logic [31:0]   sh_d;

   pfmc_pin_function_mux #(.AW(4)) pfmc_pin_function_mux_i (
      .clk         (clk),
      .resetn      (resetn),
      .compat_mode (compat_mode),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .reg_rdata   (reg_rdata),
      .pin_sel     (pin_sel)
   );

   always #5 clk = ~clk;

   // ---------------------------------------------------------------
   // Closing report and hang guard
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_errors++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------
   // Compares and bus tasks
   // ---------------------------------------------------------------
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp32

   task automatic cmp_pins(input logic [44:0] got, input logic [44:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_pins

   function automatic logic [44:0] pins_of(input logic [31:0] b, c, d);
      return {b[20:18], b[14:3], c[29:12], c[8:6], c[2:0], d[14:12], d[8:6]};
   endfunction : pins_of

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      cmp32(reg_rdata, exp);
   endtask : rd

   task automatic check_all();
      rd(`PFMC_OFS_SELECT_B, sh_b);
      rd(`PFMC_OFS_SELECT_C, sh_c);
      rd(`PFMC_OFS_SELECT_D, sh_d);
      cmp_pins(pin_sel, pins_of(sh_b, sh_c, sh_d));
   endtask : check_all

   task automatic wr_all();
      wr(`PFMC_OFS_SELECT_B, sh_b);
      wr(`PFMC_OFS_SELECT_C, sh_c);
      wr(`PFMC_OFS_SELECT_D, sh_d);
   endtask : wr_all

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      compat_mode = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      n_errors = 0;
      tests_run = 0;
      cycles = 0;
      sh_b = '0;
      sh_c = '0;
      sh_d = '0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      cmp_pins(pin_sel, '0);
      @(posedge clk);
      resetn <= 1'b1;
      check_all();
      $display("test reset values done");
      // Nonzero value in every field, then its complement
      for (int i = 0; i < 2; i++)
      begin
         sh_b = 32'h0004_2728 ^ (i[0] ? `PFMC_MASK_B : 32'h0);
         sh_c = 32'h3728_C146 ^ (i[0] ? `PFMC_MASK_C : 32'h0);
         sh_d = 32'h0000_70C0 ^ (i[0] ? `PFMC_MASK_D : 32'h0);
         wr_all();
         check_all();
      end
      wr(4'hC, 32'hFFFF_FFFF);
      rd(4'hC, 32'h0000_0000);
      check_all();
      $display("test field layout done");
      @(posedge clk);
      compat_mode <= 1'b1;
      repeat (4) @(posedge clk);
      wr(`PFMC_OFS_SELECT_C, 32'h3FFF_F1C7);
      sh_b = '0;
      sh_c = '0;
      sh_d = 32'h0000_5080;
      wr(`PFMC_OFS_SELECT_D, sh_d);
      check_all();
      @(posedge clk);
      compat_mode <= 1'b0;
      repeat (4) @(posedge clk);
      check_all();
      sh_b = 32'h001C_0000;
      sh_c = 32'h0000_0007;
      wr_all();
      check_all();
      $display("test compatibility mode done");
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      sh_b = '0;
      sh_c = '0;
      sh_d = '0;
      check_all();
      $display("test second reset done");
      stop_test();
   end
endmodule : tb_pfmc_pin_function_mux
`default_nettype wire
